// ===== design/async_register_control.sv
// the storage flip-flops of a group of logic elements and their shared asynchronous controls
// assumes all inputs are synchronous to mclk except the asynchronous controls, which act at once
`timescale 1ns/1ps
`default_nettype none

module async_register_control #(
  parameter int WIDTH = async_register_control_pkg::DEFAULT_WIDTH
) (
  input  wire logic                                         mclk,
  input  wire logic                                         rst_b,
  input  wire async_register_control_pkg::async_mode_t      mode,
  input  wire async_register_control_pkg::block_control_t   block_control,
  input  wire async_register_control_pkg::clear_sources_t   clear_sources,
  input  wire logic [WIDTH-1:0]                             data_in,
  input  wire logic [WIDTH-1:0]                             lut_input_four,
  output logic [WIDTH-1:0]                                  element_q
);

  // ----------------------------------------------------------------
  // shared control lines
  // ----------------------------------------------------------------
  logic line_a;
  logic line_b;
  logic any_clear_source;

  assign line_a           = block_control.line_a;
  assign line_b           = block_control.line_b;
  assign any_clear_source = clear_sources.global_clear | clear_sources.local_clear;

  // ----------------------------------------------------------------
  // output level that each line forces, per mode
  // ----------------------------------------------------------------
  logic a_force_zero;
  logic a_force_one;
  logic a_loads;
  logic b_force_zero;
  logic b_force_one;

  always_comb
  begin
    unique case (mode)
      async_register_control_pkg::MODE_NONE:
      begin
        // lines have no effect, register clocks and still clears from the clear sources
        a_force_zero = 1'b0;
        a_force_one  = 1'b0;
        a_loads      = 1'b0;
        b_force_zero = 1'b0;
        b_force_one  = 1'b0;
      end
      async_register_control_pkg::MODE_CLEAR:
      begin
        // either line clears
        a_force_zero = 1'b1;
        a_force_one  = 1'b0;
        a_loads      = 1'b0;
        b_force_zero = 1'b1;
        b_force_one  = 1'b0;
      end
      async_register_control_pkg::MODE_PRESET_LOAD:
      begin
        // line a loads a one, as if the fourth input were tied high
        a_force_zero = 1'b0;
        a_force_one  = 1'b1;
        a_loads      = 1'b0;
        b_force_zero = 1'b0;
        b_force_one  = 1'b0;
      end
      async_register_control_pkg::MODE_PRESET_INVERT:
      begin
        // line a presets through the clear of the inverted register
        a_force_zero = 1'b0;
        a_force_one  = 1'b1;
        a_loads      = 1'b0;
        b_force_zero = 1'b0;
        b_force_one  = 1'b0;
      end
      async_register_control_pkg::MODE_PRESET_CLEAR:
      begin
        // line a presets, line b clears
        a_force_zero = 1'b0;
        a_force_one  = 1'b1;
        a_loads      = 1'b0;
        b_force_zero = 1'b1;
        b_force_one  = 1'b0;
      end
      async_register_control_pkg::MODE_LOAD_CLEAR:
      begin
        // line a loads the fourth input, line b only clears
        a_force_zero = 1'b0;
        a_force_one  = 1'b0;
        a_loads      = 1'b1;
        b_force_zero = 1'b1;
        b_force_one  = 1'b0;
      end
      async_register_control_pkg::MODE_LOAD_PRESET:
      begin
        // line a loads the fourth input, line b presets
        a_force_zero = 1'b0;
        a_force_one  = 1'b0;
        a_loads      = 1'b1;
        b_force_zero = 1'b0;
        b_force_one  = 1'b1;
      end
      async_register_control_pkg::MODE_LOAD_ONLY:
      begin
        // line a loads the fourth input
        a_force_zero = 1'b0;
        a_force_one  = 1'b0;
        a_loads      = 1'b1;
        b_force_zero = 1'b0;
        b_force_one  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register inversion and use of the fourth input, per mode
  // ----------------------------------------------------------------
  logic invert;
  logic lut_used;

  always_comb
  begin
    unique case (mode)
      async_register_control_pkg::MODE_NONE:
      begin
        invert   = 1'b0;
        lut_used = 1'b0;
      end
      async_register_control_pkg::MODE_CLEAR:
      begin
        invert   = 1'b0;
        lut_used = 1'b0;
      end
      async_register_control_pkg::MODE_PRESET_LOAD:
      begin
        invert   = 1'b0;
        lut_used = 1'b0;
      end
      async_register_control_pkg::MODE_PRESET_INVERT:
      begin
        invert   = 1'b1;
        lut_used = 1'b0;
      end
      async_register_control_pkg::MODE_PRESET_CLEAR:
      begin
        invert   = 1'b0;
        lut_used = 1'b0;
      end
      async_register_control_pkg::MODE_LOAD_CLEAR:
      begin
        invert   = 1'b0;
        lut_used = 1'b1;
      end
      async_register_control_pkg::MODE_LOAD_PRESET:
      begin
        invert   = 1'b1;
        lut_used = 1'b1;
      end
      async_register_control_pkg::MODE_LOAD_ONLY:
      begin
        invert   = 1'b0;
        lut_used = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // per-bit controls and storage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    async_register_control_pkg::flop_control_t ctl;
    logic                                      stored_reg;
    logic                                      stored_next;
    logic                                      load_value;
    logic                                      force_zero;
    logic                                      force_one;
    logic                                      clear_req;
    logic                                      preset_req;

    // output level demanded by the lines, before the register's inversion
    always_comb
    begin
      load_value = lut_input_four[i] & lut_used;
      force_zero = (a_force_zero & line_a)
                 | (b_force_zero & line_b)
                 | (a_loads & line_a & ~load_value);
      force_one  = (a_force_one & line_a)
                 | (b_force_one & line_b)
                 | (a_loads & line_a & load_value);
      // an inverted register shows a one when its stored bit is cleared
      clear_req  = any_clear_source
                 | (invert ? force_one : force_zero);
      preset_req = invert ? force_zero : force_one;
    end

    // each control field is written once, so no zero-time pulse reaches the flop
    always_comb
    begin
      ctl.clear   = clear_req;
      ctl.preset  = preset_req & ~clear_req & rst_b;
      ctl.invert  = invert;
      stored_next = data_in[i] ^ invert;
    end

    // ----------------------------------------------------------------
    // storage flop; asynchronous controls act without the clock
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b or posedge ctl.clear or posedge ctl.preset)
    begin
      if (!rst_b)
        stored_reg <= async_register_control_pkg::STORED_RESET_VALUE;
      else if (ctl.clear)
        stored_reg <= async_register_control_pkg::STORED_CLEAR_VALUE;
      else if (ctl.preset)
        stored_reg <= async_register_control_pkg::STORED_SET_VALUE;
      else
        stored_reg <= stored_next;
    end

    assign element_q[i] = stored_reg ^ ctl.invert;
  end

endmodule : async_register_control

`default_nettype wire

// ===== design/async_register_control_pkg.sv
// holds the mode codes, carrier types and reset value for the asynchronous register control block
// assumes the mode input is static configuration, changed only while the block is held in reset
// Overview of operation
// - clear mode: either block control line asynchronously clears the register; preset stays idle
// - preset mode: load with the fourth input held high; line a forces one
// - preset may be emulated by the clear path with input and output inverted
// - single-line preset by inversion leaves the fourth input free for normal use
// - preset and clear: line a loads one, line b clears
// - load with clear: line a loads the fourth input, line b only clears
// - load with preset: line b presets via inverted clear, line a loads inverted data
// - load only: line a loads the fourth input through preset and clear
// - every register clears from local control, a global line or device reset
package async_register_control_pkg;

  // ----------------------------------------------------------------
  // operating modes of the asynchronous controls
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NONE          = 3'h0,
    MODE_CLEAR         = 3'h1,
    MODE_PRESET_LOAD   = 3'h2,
    MODE_PRESET_INVERT = 3'h3,
    MODE_PRESET_CLEAR  = 3'h4,
    MODE_LOAD_CLEAR    = 3'h5,
    MODE_LOAD_PRESET   = 3'h6,
    MODE_LOAD_ONLY     = 3'h7
  } async_mode_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic line_a;
    logic line_b;
  } block_control_t;

  typedef struct packed {
    logic global_clear;
    logic local_clear;
  } clear_sources_t;

  // raw controls seen by the storage flop of one bit
  typedef struct packed {
    logic clear;
    logic preset;
    logic invert;
  } flop_control_t;

  localparam logic STORED_RESET_VALUE = 1'h0;
  localparam logic STORED_CLEAR_VALUE = 1'h0;
  localparam logic STORED_SET_VALUE   = 1'h1;
  localparam int   DEFAULT_WIDTH      = 1;

endpackage : async_register_control_pkg

// ===== testbench/async_register_control_monitor.sv
// assertions on the register output of the asynchronous control block
// assumes mode changes only while reset is held
`timescale 1ns/1ps
`default_nettype none
module async_register_control_monitor #(parameter int WIDTH = 1) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire async_register_control_pkg::async_mode_t mode,
  input wire async_register_control_pkg::block_control_t block_control,
  input wire async_register_control_pkg::clear_sources_t clear_sources,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic [WIDTH-1:0] lut_input_four,
  input wire logic [WIDTH-1:0] element_q
);
  wire logic a = block_control.line_a;
  wire logic b = block_control.line_b;
  wire logic k = |clear_sources;
  wire logic [WIDTH-1:0] v = {WIDTH{mode == 3'h3 || mode == 3'h6}};
  wire logic [WIDTH-1:0] q = element_q;
  wire logic [WIDTH-1:0] l = lut_input_four;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_CLR: assert property (mode == 3'h1 && (a || b) |-> q == '0) else $error("clear");
  AST_PRE: assert property (mode == 3'h2 && a && !k |-> q == '1) else $error("preset");
  AST_INV: assert property (mode == 3'h3 && a |-> q == '1) else $error("inverted preset");
  AST_PC: assert property (mode == 3'h4 && (a || b) && !k |-> q == {WIDTH{!b}}) else $error("preset clear");
  AST_LC: assert property (mode == 3'h5 && (a || b) && !k |-> q == (l & {WIDTH{!b}}))
    else $error("load clear");
  AST_LP: assert property (mode == 3'h6 && (a || b) |-> q == ((b || k) ? v : l)) else $error("load preset");
  AST_LD: assert property (mode == 3'h7 && a && !k |-> q == l) else $error("load");
  AST_GLB: assert property (k |-> q == v) else $error("global clear");
  AST_CAP: assert property ((rst_b && !a && !b && !k) [*2] |-> q == $past(data_in))
    else $error("capture");
endmodule : async_register_control_monitor
bind async_register_control async_register_control_monitor #(.WIDTH(WIDTH)) mon_u (.mclk(mclk), .rst_b(rst_b),
  .mode(mode), .block_control(block_control), .clear_sources(clear_sources), .data_in(data_in),
  .lut_input_four(lut_input_four), .element_q(element_q));
`default_nettype wire

// ===== testbench/async_register_control_tb.sv
// self-checking bench for the asynchronous register controls, one bit wide
// assumes the monitor file binds its checker into the block
`timescale 1ns/1ps
`default_nettype none
module async_register_control_tb;
  logic mclk = 0, rst_b = 0, d = 0, lut = 0, st = 0, q;
  async_register_control_pkg::async_mode_t mode = async_register_control_pkg::MODE_NONE;
  async_register_control_pkg::block_control_t bc = '0;
  async_register_control_pkg::clear_sources_t cs = '0;
  int seed = 32'h230389c1, mismatches = 0, samples_checked = 0, cycles = 0;
  wire logic inv = mode == 3'h3 || mode == 3'h6;
  async_register_control dut_u (.mclk(mclk), .rst_b(rst_b), .mode(mode), .block_control(bc),
    .clear_sources(cs), .data_in(d), .lut_input_four(lut), .element_q(q));
  always #12.5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // clear and preset that the mode makes of the control levels
  // ----------------------------------------------------------------
  function automatic logic [1:0] ctl(input logic [2:0] m, input logic a, b, v, k);
    ctl[1] = k | m == 3'h1 & (a | b) | m == 3'h3 & a | m > 3'h3 & m < 3'h7 & b | a & (m == 3'h5 | m == 3'h7) & !v
      | m == 3'h6 & a & v;
    ctl[0] = a & (m == 3'h2 | m == 3'h4 | (m == 3'h5 | m == 3'h7) & v | m == 3'h6 & !v);
  endfunction : ctl
  task automatic check(input string n, input logic s, input logic e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %b seen %b", n, e, s);
    end
  endtask : check
  task automatic step(input logic [1:0] c, input logic [1:0] k, input logic v);
    logic [1:0] r;
    @(posedge mclk);
    if (ctl(mode, bc.line_a, bc.line_b, lut, |cs) == 2'h0) st = d ^ inv;
    bc <= c;
    cs <= k;
    lut <= v;
    d <= 1'($random(seed));
    @(negedge mclk);
    r = ctl(mode, bc.line_a, bc.line_b, lut, |cs);
    if (r[1]) st = 1'h0;
    else if (r[0]) st = 1'h1;
    check("element_q", q, st ^ inv);
  endtask : step
  task results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      results();
    end
  end
  initial
  begin
    for (int m = 0; m < 8; m++)
    begin
      @(posedge mclk);
      rst_b <= 1'h0;
      mode <= async_register_control_pkg::async_mode_t'(m);
      repeat (3) @(posedge mclk);
      st = 1'h0;
      check("reset", q, inv);
      rst_b <= 1'h1;
      step(2'h3, 2'h0, 1'h1);
      step(2'h0, 2'h0, 1'h0);
      repeat (60)
      begin
        step(2'($random(seed)), 2'($random(seed) & $random(seed)), 1'($random(seed)));
        step(2'h0, 2'h0, 1'($random(seed)));
      end
      $display("mode %0d done", m);
    end
    results();
  end
endmodule : async_register_control_tb
`default_nettype wire
